// file: hdl/adcp_pkg.sv
/*
  Shared constants and types for the audio converter control port:
  control word layout, register reset values, de-emphasis codes,
  initialization length and the carriers used on the top-level ports.
  Assumes one system clock domain; every pin is synchronised before use.
*/
package adcp_pkg;

  // control word layout
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam int ADDR_LO_BIT = 9;
  localparam int ADDR_HI_BIT = 10;
  localparam int LOAD_BIT = 8;
  localparam int STEP_MSB = 7;

  // register select values
  localparam logic [1:0] REG_LEFT_ATTEN = 2'h0;
  localparam logic [1:0] REG_RIGHT_ATTEN = 2'h1;

  // register reset values
  localparam logic [15:0] LEFT_ATTEN_RESET = 16'h00ff;
  localparam logic [15:0] RIGHT_ATTEN_RESET = 16'h02ff;

  // attenuation curve
  localparam logic [7:0] STEP_FULL = 8'hff;
  localparam logic [8:0] GAIN_UNITY = 9'h100;

  // de-emphasis codes, {hi pin, lo pin}
  localparam logic [1:0] DEEMPH_OFF = 2'h0;
  localparam logic [1:0] DEEMPH_48K = 2'h1;
  localparam logic [1:0] DEEMPH_44K1 = 2'h2;
  localparam logic [1:0] DEEMPH_32K = 2'h3;

  // initialization after the reset pin rises, in system clocks
  localparam int INIT_CYCLES = 1024;
  localparam logic [10:0] INIT_LAST = 11'(INIT_CYCLES - 1);

  typedef enum logic [1:0] {
    INIT_HOLD,
    INIT_COUNT,
    INIT_RUN
  } adcp_init_t;

  typedef struct packed {
    logic serial_mode;
    logic running;
    logic soft_mute;
    logic [1:0] deemph;
    logic [8:0] left_gain;
    logic [8:0] right_gain;
  } adcp_ctrl_t;

  typedef struct packed {
    logic mode_sel;
    logic reset_n_pin;
    logic ctrl_serial_data;
    logic ctrl_shift_clock;
    logic ctrl_latch;
  } adcp_pins_t;

endpackage

// file: hdl/adcp_sync.sv
/*
  Two-flop synchroniser for a bundle of asynchronous pin levels.
  Assumes the inputs are quasi-static levels; no bus coherency is implied.
*/
`timescale 1ns/1ps
module adcp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// file: hdl/adcp_top.sv
/*
  Operational control front end of a stereo audio converter: strap-selected
  pin mode or three-wire serial mode, left/right attenuation registers with
  deferred load, reset-pin sequencing and the attenuation/mute datapath.
  Assumes CLK is the system clock; all pins are asynchronous to it and the
  shift clock is slow enough to be sampled by CLK.
*/
// Overview of operation
// - mode pin low pins, high serial
// - three shared pins change meaning with mode
// - pin mode fixes all but mute, de-emphasis
// - mute pin low mutes both channels
// - de-emphasis pins decode off/48k/44.1k/32k
// - reset pin low forces bipolar zero
// - reset pin high reinitializes, then runs
// - initialization lasts 1024 system clocks
// - serial transfers are 16-bit words
// - word bits 10:9 select register
// - latch falling transfers word to register
// - register 0 low byte is left step
// - gain y/256, step 255 means 256
// - load bit clear defers applying step
// - register 1 low byte is right step
// - serial mode defaults match pin mode
`timescale 1ns/1ps
module adcp_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic MODE_SEL,
  input wire logic RESET_N_PIN,
  input wire logic CTRL_SERIAL_DATA,
  input wire logic CTRL_SHIFT_CLOCK,
  input wire logic CTRL_LATCH,
  input wire logic SAMPLE_VALID,
  input wire logic signed [15:0] SAMPLE_LEFT,
  input wire logic signed [15:0] SAMPLE_RIGHT,
  output adcp_pkg::adcp_ctrl_t CTRL,
  output logic OUT_VALID,
  output logic signed [15:0] OUT_LEFT,
  output logic signed [15:0] OUT_RIGHT
);

  adcp_pkg::adcp_pins_t pins_raw;
  adcp_pkg::adcp_pins_t pins_s;
  logic mode_s;
  logic pin_ok;
  logic data_s;
  logic clk_s;
  logic latch_s;
  logic clk_d_reg;
  logic latch_d_reg;
  logic shift_rise;
  logic latch_fall;
  logic port_en;
  logic word_take;
  logic [1:0] word_addr;
  logic [15:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] left_step_reg;
  logic [7:0] left_applied_reg;
  logic [7:0] right_step_reg;
  logic [7:0] right_applied_reg;
  adcp_pkg::adcp_init_t init_state_reg;
  logic [10:0] init_cnt_reg;

  function automatic logic [8:0] step_gain(input logic [7:0] step);
    step_gain = (step == adcp_pkg::STEP_FULL) ? adcp_pkg::GAIN_UNITY : {1'b0, step};
  endfunction

  function automatic logic signed [15:0] scale(input logic signed [15:0] s, input logic [8:0] g);
    logic signed [25:0] p;
    p = s * $signed({1'b0, g});
    scale = p[23:8];
  endfunction

  assign pins_raw.mode_sel = MODE_SEL;
  assign pins_raw.reset_n_pin = RESET_N_PIN;
  assign pins_raw.ctrl_serial_data = CTRL_SERIAL_DATA;
  assign pins_raw.ctrl_shift_clock = CTRL_SHIFT_CLOCK;
  assign pins_raw.ctrl_latch = CTRL_LATCH;

  adcp_sync #(
    .WIDTH($bits(adcp_pkg::adcp_pins_t))
  ) u_pin_sync (
    .clk(CLK),
    .rst(RST),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign mode_s = pins_s.mode_sel;
  assign pin_ok = pins_s.reset_n_pin;
  // same pins serve as deemph_sel_lo, deemph_sel_hi and soft mute in pin mode
  assign data_s = pins_s.ctrl_serial_data;
  assign clk_s = pins_s.ctrl_shift_clock;
  assign latch_s = pins_s.ctrl_latch;

  // edge detection on the synchronised copies only
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      clk_d_reg <= 1'b0;
      latch_d_reg <= 1'b0;
    end
    else
    begin
      clk_d_reg <= clk_s;
      latch_d_reg <= latch_s;
    end
  end

  assign shift_rise = clk_s & ~clk_d_reg;
  assign latch_fall = ~latch_s & latch_d_reg;
  // serial port is deaf while held in reset
  assign port_en = mode_s & pin_ok;
  assign word_addr = {shift_reg[adcp_pkg::ADDR_HI_BIT], shift_reg[adcp_pkg::ADDR_LO_BIT]};
  // short words are dropped rather than latched half-shifted
  assign word_take = port_en & latch_fall & (bit_cnt_reg == adcp_pkg::WORD_BITS);

  // shifter: msb first, one bit per shift clock rise
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end
    else if (!port_en)
    begin
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end
    else if (latch_fall)
      bit_cnt_reg <= 5'h00;
    else if (shift_rise)
    begin
      shift_reg <= {shift_reg[14:0], data_s};
      if (bit_cnt_reg != adcp_pkg::WORD_BITS)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // left attenuation register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      left_step_reg <= adcp_pkg::LEFT_ATTEN_RESET[adcp_pkg::STEP_MSB:0];
      left_applied_reg <= adcp_pkg::LEFT_ATTEN_RESET[adcp_pkg::STEP_MSB:0];
    end
    else if (!pin_ok)
    begin
      left_step_reg <= adcp_pkg::LEFT_ATTEN_RESET[adcp_pkg::STEP_MSB:0];
      left_applied_reg <= adcp_pkg::LEFT_ATTEN_RESET[adcp_pkg::STEP_MSB:0];
    end
    else if (word_take && word_addr == adcp_pkg::REG_LEFT_ATTEN)
    begin
      left_step_reg <= shift_reg[adcp_pkg::STEP_MSB:0];
      if (shift_reg[adcp_pkg::LOAD_BIT])
        left_applied_reg <= shift_reg[adcp_pkg::STEP_MSB:0];
    end
  end

  // right attenuation register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      right_step_reg <= adcp_pkg::RIGHT_ATTEN_RESET[adcp_pkg::STEP_MSB:0];
      right_applied_reg <= adcp_pkg::RIGHT_ATTEN_RESET[adcp_pkg::STEP_MSB:0];
    end
    else if (!pin_ok)
    begin
      right_step_reg <= adcp_pkg::RIGHT_ATTEN_RESET[adcp_pkg::STEP_MSB:0];
      right_applied_reg <= adcp_pkg::RIGHT_ATTEN_RESET[adcp_pkg::STEP_MSB:0];
    end
    else if (word_take && word_addr == adcp_pkg::REG_RIGHT_ATTEN)
    begin
      right_step_reg <= shift_reg[adcp_pkg::STEP_MSB:0];
      if (shift_reg[adcp_pkg::LOAD_BIT])
        right_applied_reg <= shift_reg[adcp_pkg::STEP_MSB:0];
    end
  end

  // initialization sequencer after the reset pin rises
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      init_state_reg <= adcp_pkg::INIT_HOLD;
      init_cnt_reg <= 11'h000;
    end
    else if (!pin_ok)
    begin
      init_state_reg <= adcp_pkg::INIT_HOLD;
      init_cnt_reg <= 11'h000;
    end
    else
    begin
      case (init_state_reg)
        adcp_pkg::INIT_HOLD:
        begin
          init_state_reg <= adcp_pkg::INIT_COUNT;
          init_cnt_reg <= 11'h000;
        end
        adcp_pkg::INIT_COUNT:
        begin
          if (init_cnt_reg == adcp_pkg::INIT_LAST)
            init_state_reg <= adcp_pkg::INIT_RUN;
          else
            init_cnt_reg <= init_cnt_reg + 11'h001;
        end
        adcp_pkg::INIT_RUN:
          init_state_reg <= adcp_pkg::INIT_RUN;
        default:
          init_state_reg <= adcp_pkg::INIT_HOLD;
      endcase
    end
  end

  // effective control settings
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      CTRL.serial_mode <= 1'b0;
      CTRL.running <= 1'b0;
      CTRL.soft_mute <= 1'b0;
      CTRL.deemph <= adcp_pkg::DEEMPH_OFF;
      CTRL.left_gain <= adcp_pkg::GAIN_UNITY;
      CTRL.right_gain <= adcp_pkg::GAIN_UNITY;
    end
    else
    begin
      CTRL.serial_mode <= mode_s;
      CTRL.running <= pin_ok && init_state_reg == adcp_pkg::INIT_RUN;
      if (!pin_ok)
      begin
        CTRL.soft_mute <= 1'b0;
        CTRL.deemph <= adcp_pkg::DEEMPH_OFF;
        CTRL.left_gain <= adcp_pkg::GAIN_UNITY;
        CTRL.right_gain <= adcp_pkg::GAIN_UNITY;
      end
      else if (mode_s)
      begin
        // mute and de-emphasis live in register 2, held at defaults here
        CTRL.soft_mute <= 1'b0;
        CTRL.deemph <= adcp_pkg::DEEMPH_OFF;
        CTRL.left_gain <= step_gain(left_applied_reg);
        CTRL.right_gain <= step_gain(right_applied_reg);
      end
      else
      begin
        CTRL.soft_mute <= ~latch_s;
        CTRL.deemph <= {clk_s, data_s};
        CTRL.left_gain <= adcp_pkg::GAIN_UNITY;
        CTRL.right_gain <= adcp_pkg::GAIN_UNITY;
      end
    end
  end

  // datapath: mute is immediate, no ramp, so a click is possible
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      OUT_VALID <= 1'b0;
      OUT_LEFT <= 16'sh0000;
      OUT_RIGHT <= 16'sh0000;
    end
    else
    begin
      OUT_VALID <= SAMPLE_VALID;
      if (!CTRL.running)
      begin
        OUT_LEFT <= 16'sh0000;
        OUT_RIGHT <= 16'sh0000;
      end
      else if (SAMPLE_VALID)
      begin
        OUT_LEFT <= CTRL.soft_mute ? 16'sh0000 : scale(SAMPLE_LEFT, CTRL.left_gain);
        OUT_RIGHT <= CTRL.soft_mute ? 16'sh0000 : scale(SAMPLE_RIGHT, CTRL.right_gain);
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // mode flag lags the synchronised strap by one edge
  property p_mode;
    $stable(mode_s) |=> CTRL.serial_mode == $past(mode_s);
  endproperty
  a_mode: assert property (p_mode) else $error("mode flag does not follow strap");
  property p_hw_fixed;
    (pin_ok && !mode_s) |=> (CTRL.left_gain == 9'h100 && CTRL.right_gain == 9'h100);
  endproperty
  a_hw_fixed: assert property (p_hw_fixed) else $error("pin mode gain not unity");
  property p_hw_mute;
    (pin_ok && !mode_s) |=> CTRL.soft_mute == !$past(latch_s);
  endproperty
  a_hw_mute: assert property (p_hw_mute) else $error("pin mode mute wrong");
  property p_hw_deemph;
    (pin_ok && !mode_s) |=> CTRL.deemph == {$past(clk_s), $past(data_s)};
  endproperty
  a_hw_deemph: assert property (p_hw_deemph) else $error("pin mode de-emphasis wrong");
  property p_reset_zero;
    !pin_ok |=> !CTRL.running ##1 (OUT_LEFT == 16'sh0000 && OUT_RIGHT == 16'sh0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("output not zero in reset");
  property p_init_len;
    (init_state_reg == adcp_pkg::INIT_RUN) |-> init_cnt_reg == adcp_pkg::INIT_LAST;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init ended at wrong count");
  property p_init_done;
    (pin_ok && init_state_reg == adcp_pkg::INIT_COUNT && init_cnt_reg == adcp_pkg::INIT_LAST) |=> ##1 CTRL.running;
  endproperty
  a_init_done: assert property (p_init_done) else $error("running not raised after init");
  property p_shift;
    (port_en && shift_rise && !latch_fall) |=> shift_reg[0] == $past(data_s);
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not captured");
  property p_short_word;
    (port_en && latch_fall && bit_cnt_reg != 5'h10) |=> $stable(left_step_reg) && $stable(right_step_reg);
  endproperty
  a_short_word: assert property (p_short_word) else $error("short word was latched");
  property p_high_addr;
    (word_take && word_addr[1]) |=> $stable(left_step_reg) && $stable(right_step_reg);
  endproperty
  a_high_addr: assert property (p_high_addr) else $error("register 2 or 3 hit attenuation");
  property p_left_load;
    (word_take && word_addr == 2'h0 && shift_reg[8]) |=> left_applied_reg == $past(shift_reg[7:0]);
  endproperty
  a_left_load: assert property (p_left_load) else $error("left load not applied");
  property p_left_defer;
    (word_take && word_addr == 2'h0 && !shift_reg[8])
      |=> $stable(left_applied_reg) && left_step_reg == $past(shift_reg[7:0]);
  endproperty
  a_left_defer: assert property (p_left_defer) else $error("left deferred load wrong");
  property p_right_load;
    (word_take && word_addr == 2'h1) |=> right_step_reg == $past(shift_reg[7:0]) && $stable(left_step_reg);
  endproperty
  a_right_load: assert property (p_right_load) else $error("right register write wrong");
  property p_curve;
    (pin_ok && mode_s) |=> CTRL.left_gain == (($past(left_applied_reg) == 8'hff) ? 9'h100
      : {1'b0, $past(left_applied_reg)});
  endproperty
  a_curve: assert property (p_curve) else $error("attenuation curve wrong");
  property p_unity;
    (SAMPLE_VALID && CTRL.running && !CTRL.soft_mute && CTRL.left_gain == 9'h100)
      |=> OUT_LEFT == $past(SAMPLE_LEFT);
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain altered sample");
  property p_sw_default;
    (pin_ok && mode_s) |=> (!CTRL.soft_mute && CTRL.deemph == 2'h0);
  endproperty
  a_sw_default: assert property (p_sw_default) else $error("serial mode defaults wrong");

  c_left_load: cover property (word_take && word_addr == 2'h0 && shift_reg[8]);
  c_left_defer: cover property (word_take && word_addr == 2'h0 && !shift_reg[8]);
  c_hw_mute: cover property (pin_ok && !mode_s && !latch_s);
  c_init_done: cover property ($rose(CTRL.running));

endmodule

// file: testbench/adcp_host_model.sv
/*
  Host model for the three-wire control port and the shared strap pins.
  Assumes clk is the bench system clock and callers start just after a rising edge.
*/
`timescale 1ns/1ps
module adcp_host_model (
  input wire logic clk,
  output logic sdata,
  output logic sclk,
  output logic latch
);
  initial
  begin
    sdata = 1'b0;
    sclk = 1'b0;
    latch = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  // shift clock stands low outside frames; 800 ns per bit
  task automatic send(input logic [15:0] w, input int nbits);
    int i;
    latch = 1'b1;
    for (i = 15; i > 15 - nbits; i--)
    begin
      sdata = w[i];
      wait_clk(4);
      sclk = 1'b1;
      wait_clk(4);
      sclk = 1'b0;
    end
    // released data line must not look like a held bit
    sdata = ~sdata;
    wait_clk(4);
    latch = 1'b0;
    wait_clk(4);
    latch = 1'b1;
  endtask

  task automatic pins(input logic lo, input logic hi, input logic mute_n);
    sdata = lo;
    sclk = hi;
    latch = mute_n;
  endtask
endmodule

// file: testbench/audio_dac_control_port_tb_top.sv
/*
  Self-checking bench for the control port: init, serial writes, pin mode, reset pin.
  Assumes the host model drives the three shared pins and CTRL is registered.
*/
`timescale 1ns/1ps
module audio_dac_control_port_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode_sel = 1'b1;
  logic reset_n_pin = 1'b1;
  logic sample_valid = 1'b0;
  logic signed [15:0] sample_left = 16'h0000;
  logic signed [15:0] sample_right = 16'h0000;
  logic sdata;
  logic sclk;
  logic latch;
  adcp_pkg::adcp_ctrl_t ctrl;
  logic out_valid;
  logic signed [15:0] out_left;
  logic signed [15:0] out_right;
  int bad_count = 0;
  int samples_checked = 0;

  always #50 clk = ~clk;

  adcp_host_model host (.clk(clk), .sdata(sdata), .sclk(sclk), .latch(latch));

  adcp_top DUT (
    .CLK(clk), .RST(rst), .MODE_SEL(mode_sel), .RESET_N_PIN(reset_n_pin),
    .CTRL_SERIAL_DATA(sdata), .CTRL_SHIFT_CLOCK(sclk), .CTRL_LATCH(latch),
    .SAMPLE_VALID(sample_valid), .SAMPLE_LEFT(sample_left), .SAMPLE_RIGHT(sample_right),
    .CTRL(ctrl), .OUT_VALID(out_valid), .OUT_LEFT(out_left), .OUT_RIGHT(out_right)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_gain(input logic [8:0] got, input logic [8:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_gains(input logic [8:0] gl, input logic [8:0] gr);
    chk_gain(ctrl.left_gain, gl, "left gain");
    chk_gain(ctrl.right_gain, gr, "right gain");
  endtask

  task automatic play(input logic signed [15:0] sl, input logic signed [15:0] sr,
                      input logic [8:0] gl, input logic [8:0] gr);
    logic signed [31:0] pl;
    logic signed [31:0] pr;
    pl = sl * $signed({1'b0, gl});
    pr = sr * $signed({1'b0, gr});
    sample_left = sl;
    sample_right = sr;
    sample_valid = 1'b1;
    cyc(1);
    // out valid stands for one cycle only
    chk_flag(out_valid, 1'b1, "out valid");
    chk_out(out_left, pl[23:8], "left out");
    chk_out(out_right, pr[23:8], "right out");
    sample_valid = 1'b0;
    cyc(1);
    chk_flag(out_valid, 1'b0, "out valid drop");
  endtask

  task automatic wr(input logic [1:0] a, input logic ld, input logic [7:0] st);
    host.send({5'h00, a, ld, st}, 16);
    cyc(6);
  endtask

  // running must rise about 1026 edges after the pin is seen high
  task automatic wait_init;
    cyc(1010);
    chk_flag(ctrl.running, 1'b0, "running early");
    cyc(40);
    chk_flag(ctrl.running, 1'b1, "running late");
  endtask

  task automatic t_init;
    wait_init();
    chk_flag(ctrl.serial_mode, 1'b1, "serial mode");
    chk_gains(9'h100, 9'h100);
    chk_flag(ctrl.soft_mute, 1'b0, "mute default");
    chk_gain({7'h00, ctrl.deemph}, {7'h00, adcp_pkg::DEEMPH_OFF}, "deemph default");
    play(16'h1234, 16'hedcc, 9'h100, 9'h100);
    $display("init test done");
  endtask

  task automatic t_serial;
    int i;
    wr(adcp_pkg::REG_LEFT_ATTEN, 1'b1, 8'h80);
    chk_gains(9'h080, 9'h100);
    play(16'h4000, 16'h8001, 9'h080, 9'h100);
    wr(adcp_pkg::REG_LEFT_ATTEN, 1'b0, 8'h01);
    chk_gains(9'h080, 9'h100);
    wr(adcp_pkg::REG_LEFT_ATTEN, 1'b1, 8'h01);
    chk_gains(9'h001, 9'h100);
    wr(adcp_pkg::REG_RIGHT_ATTEN, 1'b1, 8'hfe);
    chk_gains(9'h001, 9'h0fe);
    wr(adcp_pkg::REG_RIGHT_ATTEN, 1'b0, 8'h00);
    chk_gains(9'h001, 9'h0fe);
    wr(adcp_pkg::REG_RIGHT_ATTEN, 1'b1, 8'h00);
    chk_gains(9'h001, 9'h000);
    for (i = 2; i < 4; i++)
    begin
      wr(2'(i), 1'b1, 8'h10);
      chk_gains(9'h001, 9'h000);
    end
    // one bit short of a word: must be dropped
    host.send({5'h00, 2'h0, 1'b1, 8'h20}, 15);
    cyc(6);
    chk_gains(9'h001, 9'h000);
    play(16'h7fff, 16'h7fff, 9'h001, 9'h000);
    $display("serial test done");
  endtask

  task automatic t_pin_mode;
    logic [1:0] dtab [4];
    logic [2:0] k;
    int i;
    dtab = '{adcp_pkg::DEEMPH_OFF, adcp_pkg::DEEMPH_48K, adcp_pkg::DEEMPH_44K1, adcp_pkg::DEEMPH_32K};
    mode_sel = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      k = 3'(i);
      host.pins(k[0], k[1], k[2]);
      cyc(6);
      chk_flag(ctrl.serial_mode, 1'b0, "pin mode");
      chk_gain({7'h00, ctrl.deemph}, {7'h00, dtab[k[1:0]]}, "deemph");
      chk_flag(ctrl.soft_mute, ~k[2], "mute");
      chk_gains(9'h100, 9'h100);
      play(16'h2345, 16'hc001, k[2] ? 9'h100 : 9'h000, k[2] ? 9'h100 : 9'h000);
    end
    host.pins(1'b0, 1'b0, 1'b1);
    mode_sel = 1'b1;
    cyc(6);
    $display("pin mode test done");
  endtask

  task automatic t_reset_pin;
    wr(adcp_pkg::REG_LEFT_ATTEN, 1'b1, 8'h40);
    chk_gains(9'h040, 9'h000);
    reset_n_pin = 1'b0;
    cyc(6);
    chk_flag(ctrl.running, 1'b0, "held in reset");
    play(16'h7000, 16'h9000, 9'h000, 9'h000);
    reset_n_pin = 1'b1;
    wait_init();
    chk_gains(9'h100, 9'h100);
    play(16'h7000, 16'h9000, 9'h100, 9'h100);
    $display("reset pin test done");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // whole run is near 3600 cycles
  initial
  begin
    #1500000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    cyc(12);
    rst = 1'b0;
    t_init();
    t_serial();
    t_pin_mode();
    t_reset_pin();
    stop_test();
  end
endmodule
